// [logic/scsp_params.svh]
`ifndef SCSP_PARAMS_SVH
`define SCSP_PARAMS_SVH
// ==========================================================
// timing
`define SCSP_CLK_MHZ      250
`define SCSP_BIT_NS       10000
`define SCSP_BIT_CYC      ((`SCSP_BIT_NS * `SCSP_CLK_MHZ) / 1000)
`define SCSP_HALF_CYC     (`SCSP_BIT_CYC / 2)
`define SCSP_MID_MIN_CYC  ((`SCSP_BIT_CYC * 3) / 4)
`define SCSP_TIMEOUT_CYC  (2 * `SCSP_BIT_CYC)
`define SCSP_STATUS_CYC   (10 * `SCSP_BIT_CYC)
`define SCSP_CNT_W        16
// ==========================================================
// command layout
`define SCSP_SYNC         4'hC
`define SCSP_HDR_BITS     6
`define SCSP_WR_BITS      12
// ==========================================================
// readback frame, position 0 leaves the pin first
`define SCSP_FRAME_LEN    37
`define SCSP_POS_START    0
`define SCSP_POS_ERR      1
`define SCSP_POS_CA       11
`define SCSP_POS_AGC      12
`define SCSP_POS_LED      14
`define SCSP_POS_BANK     24
// ==========================================================
// configuration bank fields and resets
`define SCSP_BANK_W       6
`define SCSP_BIT_POL      5
`define SCSP_BIT_DRV      4
`define SCSP_BANK_RST     6'h00
`define SCSP_FIFO_DEPTH   8
`endif

// [logic/scsp_pkg.sv]
`include "scsp_params.svh"
package scsp_pkg;
    typedef enum logic [6:0] {
        S_LOAD   = 7'h01,
        S_IDLE   = 7'h02,
        S_WRITE  = 7'h04,
        S_VERIFY = 7'h08,
        S_READ   = 7'h10,
        S_CAL    = 7'h20,
        S_STAT   = 7'h40
    } scsp_state_t;
    typedef enum logic [1:0] {
        OP_NOP   = 2'h0,
        OP_READ  = 2'h1,
        OP_WRITE = 2'h2,
        OP_CAL   = 2'h3
    } scsp_op_t;
endpackage : scsp_pkg

// [logic/scsp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module scsp_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,       // clock
    input  wire logic             reset_i,     // async reset, high
    input  wire logic             in_valid_i,  // push request
    output logic                  in_ready_o,  // not full
    input  wire logic [WIDTH-1:0] in_data_i,   // push data
    output logic                  out_valid_o, // not empty
    input  wire logic             out_ready_i, // pop request
    output logic [WIDTH-1:0]      out_data_o   // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("scsp_fifo: depth must be at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // count is one bit wider than the pointers so that a full buffer is representable
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem[rptr];

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : wrap_inc

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= wrap_inc(wptr);
            end
            if (pop) begin
                rptr <= wrap_inc(rptr);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end
endmodule : scsp_fifo
`default_nettype wire

// [logic/scsp_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scsp_params.svh"
module scsp_top
    import scsp_pkg::*;
#(
    parameter int TIMEOUT_CYC = `SCSP_TIMEOUT_CYC,
    parameter int STATUS_CYC  = `SCSP_STATUS_CYC,
    parameter int FIFO_DEPTH  = `SCSP_FIFO_DEPTH
) (
    input  wire logic                    clk_i,              // 250 MHz clock
    input  wire logic                    reset_i,            // async reset, high
    input  wire logic                    cmd_pin_i,          // command pin level
    output logic                         cmd_pin_o,          // command pin drive value
    output logic                         cmd_pin_oe_o,       // command pin drive enable
    input  wire logic                    detect_i,           // comparator result
    output logic                         out_pin_o,          // detection pin value
    output logic                         out_pin_oe_o,       // detection pin enable
    output logic [3:0]                   thresh_code_o,      // comparator threshold code
    output logic                         nv_we_o,            // bank write strobe
    output logic [`SCSP_BANK_W-1:0]      nv_wdata_o,         // bank write data
    input  wire logic [`SCSP_BANK_W-1:0] nv_rdata_i,         // bank stored contents
    output logic                         cal_start_o,        // calibration start pulse
    input  wire logic                    cal_done_i,         // calibration done pulse
    input  wire logic                    cal_ok_i,           // calibration result
    input  wire logic                    trim_success_flag_i,// stored calibration flag
    input  wire logic [1:0]              gain_step_bits_i,   // stored gain step
    input  wire logic [9:0]              led_count_i,        // stored LED drive count
    output logic                         rx_ready_o          // command buffer not full
);
    localparam int CW = `SCSP_CNT_W;
    generate
        if (TIMEOUT_CYC <= `SCSP_BIT_CYC || TIMEOUT_CYC >= (1 << CW) ||
            STATUS_CYC < 1 || STATUS_CYC >= (1 << CW) || FIFO_DEPTH < 2) begin : g_bad
            $error("scsp_top: parameter out of range");
        end
    endgenerate

    // ==========================================================
    // pin synchronisers
    logic          rx_s1, rx_s2, rx_s3;
    logic          det_s1, det_s2;
    logic [2:0]    mute_sh;
    logic          rx_mute;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_s1  <= 1'b0;
            rx_s2  <= 1'b0;
            rx_s3  <= 1'b0;
            det_s1 <= 1'b0;
            det_s2 <= 1'b0;
        end else begin
            rx_s1  <= cmd_pin_i;
            rx_s2  <= rx_s1;
            rx_s3  <= rx_s2;
            det_s1 <= detect_i;
            det_s2 <= det_s1;
        end
    end

    // ==========================================================
    // Manchester receiver on the command pin
    scsp_state_t   st, next_st;
    logic [CW-1:0] gap_cnt;
    logic          in_frame;
    logic          rx_edge, rx_acc, rx_end;
    logic          rx_valid;
    logic [1:0]    rx_tok;

    // own status drive echoes back through the synchroniser
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mute_sh <= '0;
        end else begin
            mute_sh <= {mute_sh[1:0], cmd_pin_oe_o};
        end
    end
    // the drive enable lags the state, so its release edge needs the longer shadow
    assign rx_mute  = (st == S_STAT) | cmd_pin_oe_o | (|mute_sh);
    assign rx_edge  = (rx_s2 ^ rx_s3) & ~rx_mute;
    // boundary edges come half a bit after a mid edge and are skipped
    assign rx_acc   = rx_edge & (~in_frame | (gap_cnt >= CW'(`SCSP_MID_MIN_CYC)));
    // muting cuts an open frame, so close it for the parser as well
    assign rx_end   = in_frame & ~rx_acc
                    & ((gap_cnt == CW'(TIMEOUT_CYC - 1)) | rx_mute);
    assign rx_valid = rx_acc | rx_end;
    // token: {frame end, data bit}; a rising mid edge is a 1
    assign rx_tok   = rx_acc ? {1'b0, rx_s2} : 2'b10;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gap_cnt  <= '0;
            in_frame <= 1'b0;
        end else if (rx_mute) begin
            gap_cnt  <= '0;
            in_frame <= 1'b0;
        end else if (rx_acc) begin
            gap_cnt  <= '0;
            in_frame <= 1'b1;
        end else if (rx_end) begin
            gap_cnt  <= '0;
            in_frame <= 1'b0;
        end else if (in_frame) begin
            gap_cnt  <= gap_cnt + CW'(1);
        end
    end

    // ==========================================================
    // command buffer, drained only while idle
    logic       tok_valid;
    logic [1:0] tok;
    logic       pop;

    assign pop = tok_valid & (st == S_IDLE);

    scsp_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (rx_valid),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_tok),
        .out_valid_o (tok_valid),
        .out_ready_i (pop),
        .out_data_o  (tok)
    );

    // ==========================================================
    // command parser
    logic [3:0]              bit_cnt;
    logic [5:0]              hdr;
    logic [`SCSP_BANK_W-1:0] wr_sh;
    logic                    skip;
    logic                    wr_pend;
    logic                    take;
    logic [5:0]              hdr6;
    logic                    hdr_ok;
    logic                    cmd_rd, cmd_cal, cmd_wr;

    assign take    = pop & ~tok[1] & ~skip;
    assign hdr6    = {hdr[4:0], tok[0]};
    assign hdr_ok  = take & (bit_cnt == 4'(`SCSP_HDR_BITS - 1))
                   & (hdr6[5:2] == `SCSP_SYNC);
    assign cmd_rd  = hdr_ok & (hdr6[1:0] == OP_READ);
    assign cmd_cal = hdr_ok & (hdr6[1:0] == OP_CAL);
    assign cmd_wr  = take & wr_pend & (bit_cnt == 4'(`SCSP_WR_BITS - 1));

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt <= '0;
            hdr     <= '0;
            wr_sh   <= '0;
            skip    <= 1'b0;
            wr_pend <= 1'b0;
        end else if (pop && tok[1]) begin
            bit_cnt <= '0;
            skip    <= 1'b0;
            wr_pend <= 1'b0;
        end else if (take) begin
            bit_cnt <= bit_cnt + 4'(1);
            hdr     <= hdr6;
            // data arrives bit 0 first, so shift in from the top
            wr_sh   <= {tok[0], wr_sh[`SCSP_BANK_W-1:1]};
            if (bit_cnt == 4'(`SCSP_HDR_BITS - 1)) begin
                wr_pend <= hdr_ok & (hdr6[1:0] == OP_WRITE);
                skip    <= ~(hdr_ok & (hdr6[1:0] == OP_WRITE));
            end
            if (cmd_wr) begin
                wr_pend <= 1'b0;
                skip    <= 1'b1;
            end
        end
    end

    // ==========================================================
    // sequencer
    logic [CW-1:0] cyc_cnt;
    logic [5:0]    tx_idx;
    logic          tx_last;
    logic          stat_last;

    assign tx_last   = (tx_idx == 6'(`SCSP_FRAME_LEN - 1))
                     & (cyc_cnt == CW'(`SCSP_BIT_CYC - 1));
    assign stat_last = (cyc_cnt == CW'(STATUS_CYC - 1));

    always_comb begin
        next_st = st;
        unique case (st)
            S_LOAD:   next_st = S_IDLE;
            S_IDLE: begin
                if (cmd_wr) begin
                    next_st = S_WRITE;
                end else if (cmd_rd) begin
                    next_st = S_READ;
                end else if (cmd_cal) begin
                    next_st = S_CAL;
                end
            end
            S_WRITE:  next_st = S_VERIFY;
            S_VERIFY: next_st = S_IDLE;
            S_READ:   next_st = tx_last ? S_IDLE : S_READ;
            S_CAL:    next_st = cal_done_i ? S_STAT : S_CAL;
            S_STAT:   next_st = stat_last ? S_IDLE : S_STAT;
            default:  next_st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= S_LOAD;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // bank, verify and error flag
    logic [`SCSP_BANK_W-1:0] output_config_bank;
    logic                    err_flag;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            output_config_bank <= `SCSP_BANK_RST;
            nv_wdata_o         <= '0;
            err_flag           <= 1'b0;
        end else begin
            if (cmd_wr) begin
                nv_wdata_o <= {tok[0], wr_sh[`SCSP_BANK_W-1:1]};
            end
            // bank follows what the store really holds, not what was sent
            if (st == S_LOAD || st == S_VERIFY) begin
                output_config_bank <= nv_rdata_i;
            end
            if (st == S_VERIFY) begin
                err_flag <= (nv_rdata_i != nv_wdata_o);
            end
        end
    end

    assign nv_we_o       = (st == S_WRITE);
    assign thresh_code_o = output_config_bank[3:0];

    // ==========================================================
    // readback frame builder
    function automatic logic [`SCSP_FRAME_LEN-1:0] build_frame(
        input logic                    err,
        input logic                    ca,
        input logic [1:0]              gain_step_bits,
        input logic [9:0]              led,
        input logic [`SCSP_BANK_W-1:0] bank
    );
        logic [`SCSP_FRAME_LEN-1:0] f;
        // reserved and trailing positions stay zero
        f                            = '0;
        f[`SCSP_POS_START]           = 1'b0;
        f[`SCSP_POS_ERR]             = err;
        f[`SCSP_POS_CA]              = ca;
        f[`SCSP_POS_AGC +: 2]        = gain_step_bits;
        f[`SCSP_POS_LED +: 10]       = led;
        f[`SCSP_POS_BANK +: `SCSP_BANK_W] = bank;
        build_frame = f;
    endfunction : build_frame

    // ==========================================================
    // cycle counter, transmitter and status drive
    logic [`SCSP_FRAME_LEN-1:0] tx_sh;
    logic                       tx_line;
    logic                       cal_res;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cyc_cnt <= '0;
            tx_idx  <= '0;
            tx_sh   <= '0;
            tx_line <= 1'b0;
        end else if (st == S_IDLE && cmd_rd) begin
            cyc_cnt <= '0;
            tx_idx  <= '0;
            // start bit is 0, so the first half is high; no stale level leaks out
            tx_line <= 1'b1;
            tx_sh   <= build_frame(err_flag, trim_success_flag_i, gain_step_bits_i,
                                   led_count_i, output_config_bank);
        end else if (st == S_READ) begin
            // first half is the inverse, second half the bit itself
            tx_line <= (cyc_cnt < CW'(`SCSP_HALF_CYC)) ? ~tx_sh[0] : tx_sh[0];
            if (cyc_cnt == CW'(`SCSP_BIT_CYC - 1)) begin
                cyc_cnt <= '0;
                tx_idx  <= tx_idx + 6'(1);
                tx_sh   <= {1'b0, tx_sh[`SCSP_FRAME_LEN-1:1]};
            end else begin
                cyc_cnt <= cyc_cnt + CW'(1);
            end
        end else if (st == S_STAT) begin
            cyc_cnt <= stat_last ? '0 : cyc_cnt + CW'(1);
        end else begin
            cyc_cnt <= '0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cal_start_o  <= 1'b0;
            cal_res      <= 1'b0;
            cmd_pin_o    <= 1'b0;
            cmd_pin_oe_o <= 1'b0;
        end else begin
            cal_start_o  <= (st == S_IDLE) & cmd_cal;
            if (st == S_CAL && cal_done_i) begin
                cal_res <= cal_ok_i;
            end
            cmd_pin_o    <= cal_res;
            cmd_pin_oe_o <= (st == S_STAT);
        end
    end

    // ==========================================================
    // detection pin driver
    logic out_val;

    // the readback bypasses polarity so the host sees raw bits
    assign out_val = (st == S_READ) ? tx_line
                   : det_s2 ^ output_config_bank[`SCSP_BIT_POL];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_pin_o    <= 1'b0;
            out_pin_oe_o <= 1'b0;
        end else if (output_config_bank[`SCSP_BIT_DRV]) begin
            out_pin_o    <= out_val;
            out_pin_oe_o <= 1'b1;
        end else begin
            // open drain only ever pulls low
            out_pin_o    <= 1'b0;
            out_pin_oe_o <= ~out_val;
        end
    end
endmodule : scsp_top
`default_nettype wire

// [bench/scsp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scsp_host_model (
    input  wire logic clk_i,  // bench clock
    output logic      line_o  // host drive of command pin
);
    localparam int HALF = 1250;
    initial line_o = 1'b0;
    // ==========
    // command sender
    // frames must open with a 1, so the first edge seen is a mid-bit edge
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            line_o = ~bits[i];
            repeat (HALF) @(negedge clk_i);
            line_o = bits[i];
            repeat (HALF) @(negedge clk_i);
        end
        line_o = 1'b0;  // idle low, late edge falls inside the dead band
    endtask : send
endmodule : scsp_host_model
`default_nettype wire

// [bench/scsp_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scsp_params.svh"
module scsp_checker #(
    parameter int STATUS_CYC = `SCSP_STATUS_CYC
) (
    input wire logic                    clk_i,         // clock
    input wire logic                    reset_i,       // reset
    input wire logic                    cmd_pin_o,     // status value
    input wire logic                    cmd_pin_oe_o,  // status enable
    input wire logic                    out_pin_o,     // out value
    input wire logic                    out_pin_oe_o,  // out enable
    input wire logic [3:0]              thresh_code_o, // threshold
    input wire logic                    nv_we_o,       // bank write
    input wire logic [`SCSP_BANK_W-1:0] nv_rdata_i,    // bank store
    input wire logic                    cal_start_o,   // cal start
    input wire logic                    cal_done_i,    // cal done
    input wire logic                    cal_ok_i       // cal result
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [31:0] oe_cnt;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i)
            oe_cnt <= '0;
        else if (cmd_pin_oe_o)
            oe_cnt <= oe_cnt + 32'h1;
        else
            oe_cnt <= '0;
    end
    // ==========
    // status mode
    sequence s_cal_done; cal_done_i; endsequence
    sequence s_drive_result; cmd_pin_oe_o && (cmd_pin_o == $past(cal_ok_i, 2)); endsequence
    sequence s_hold; cmd_pin_oe_o && $stable(cmd_pin_o); endsequence
    // state moves on the done edge, the registered drive follows one edge later
    property p_status_start; s_cal_done |-> ##2 s_drive_result; endproperty
    property p_status_hold; $rose(cmd_pin_oe_o) |=> s_hold [*8]; endproperty
    property p_status_len; $fell(cmd_pin_oe_o) |-> oe_cnt == STATUS_CYC; endproperty
    // ==========
    // strobes, bank and output pin
    property p_we_pulse; nv_we_o |=> !nv_we_o; endproperty
    property p_cal_pulse; cal_start_o |=> !cal_start_o; endproperty
    property p_thresh_load;
        nv_we_o |-> ##[2:4] (thresh_code_o == nv_rdata_i[3:0]);
    endproperty
    // the reload from the store after reset is the only other cause of change
    property p_thresh_quiet;
        $changed(thresh_code_o) |-> $past(nv_we_o) || $past(nv_we_o, 2) || $past(nv_we_o, 3)
            || $past(reset_i) || $past(reset_i, 2) || $past(reset_i, 3);
    endproperty
    property p_od_low; !out_pin_oe_o |-> !out_pin_o; endproperty
    a_status_start: assert property (p_status_start)
        else $error("status drive does not follow calibration result");
    a_status_hold: assert property (p_status_hold)
        else $error("status drive unsteady");
    a_status_len: assert property (p_status_len)
        else $error("status drive length wrong");
    a_we_pulse: assert property (p_we_pulse)
        else $error("bank write strobe too long");
    a_cal_pulse: assert property (p_cal_pulse)
        else $error("calibration start strobe too long");
    a_thresh_load: assert property (p_thresh_load)
        else $error("threshold not taken from verified bank");
    a_thresh_quiet: assert property (p_thresh_quiet)
        else $error("threshold changed without a write");
    a_od_low: assert property (p_od_low)
        else $error("released output pin carries a high value");
endmodule : scsp_checker
bind scsp_top scsp_checker #(.STATUS_CYC(STATUS_CYC)) i_scsp_checker (
    .clk_i(clk_i), .reset_i(reset_i), .cmd_pin_o(cmd_pin_o), .cmd_pin_oe_o(cmd_pin_oe_o),
    .out_pin_o(out_pin_o), .out_pin_oe_o(out_pin_oe_o), .thresh_code_o(thresh_code_o),
    .nv_we_o(nv_we_o), .nv_rdata_i(nv_rdata_i), .cal_start_o(cal_start_o),
    .cal_done_i(cal_done_i), .cal_ok_i(cal_ok_i));
`default_nettype wire

// [bench/tb_sensor_config_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_config_serial_port;
    localparam int STAT  = 50;
    localparam int LIMIT = 160000;
    logic       clk = 1'b0, reset = 1'b1, detect = 1'b0;
    logic       cal_done = 1'b0, cal_ok = 1'b0, corrupt = 1'b0;
    logic       ca = 1'b1, rx_rdy;
    logic [1:0] gain_step_bits = 2'h1;
    logic [9:0] led = 10'h03B;
    logic       host_line, cmd_line, cmd_o, cmd_oe, out_o, out_oe, nv_we, cal_start;
    logic [3:0] thresh;
    logic [5:0] wdata, store = 6'h00;
    int         errors = 0, n_compared = 0, cycles = 0;
    assign cmd_line = cmd_oe ? cmd_o : host_line;
    always #2 clk = ~clk;
    // bank store; corrupt flips bit 0 to force a verify mismatch
    always @(posedge clk) if (nv_we) store <= wdata ^ {5'h00, corrupt};
    scsp_top #(.TIMEOUT_CYC(3000), .STATUS_CYC(STAT)) i_scsp_top (
        .clk_i(clk), .reset_i(reset), .cmd_pin_i(cmd_line), .cmd_pin_o(cmd_o),
        .cmd_pin_oe_o(cmd_oe), .detect_i(detect), .out_pin_o(out_o), .out_pin_oe_o(out_oe),
        .thresh_code_o(thresh), .nv_we_o(nv_we), .nv_wdata_o(wdata), .nv_rdata_i(store),
        .cal_start_o(cal_start), .cal_done_i(cal_done), .cal_ok_i(cal_ok),
        .trim_success_flag_i(ca), .gain_step_bits_i(gain_step_bits), .led_count_i(led),
        .rx_ready_o(rx_rdy));
    scsp_host_model i_scsp_host_model (.clk_i(clk), .line_o(host_line));
    // ==========
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    task automatic finish_test;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("[ERR] %0t run limit reached", $time);
            finish_test();
        end
    end
    // ==========
    // scenarios
    task automatic t_open_drain;
        detect = 1'b1;
        cyc(8);
        check(out_oe === 1'b0, "open drain not released");
        detect = 1'b0;
        cyc(8);
        check(out_oe === 1'b1 && out_o === 1'b0, "open drain not pulling");
        check(thresh === 4'h0, "threshold after load");
        check(rx_rdy === 1'b1, "command buffer full after reset");
    endtask : t_open_drain
    task automatic t_write;
        int n;
        corrupt = 1'b1;
        n = 0;
        fork
            i_scsp_host_model.send({4'hC, 2'h2, 6'h07}, 12);
            while (nv_we !== 1'b1 && n < 40000) begin
                cyc(1);
                n++;
            end
        join
        check(n < 40000 && wdata === 6'h38, "bank write data");
        cyc(10);
        check(thresh === 4'h9, "threshold from verified bank");
        detect = 1'b1;
        cyc(8);
        check(out_oe === 1'b1 && out_o === 1'b0, "push-pull inverted low");
        detect = 1'b0;
        cyc(8);
        check(out_oe === 1'b1 && out_o === 1'b1, "push-pull inverted high");
        cyc(3000);
    endtask : t_write
    task automatic t_read;
        logic [36:0] ef;
        int          n;
        ef = '0;
        ef[1] = 1'b1;
        ef[11] = 1'b1;
        ef[13:12] = 2'h1;
        ef[23:14] = 10'h03B;
        ef[29:24] = 6'h39;
        n = 0;
        // detection idles high here, so the start bit shows as a fall
        fork
            i_scsp_host_model.send(12'h031, 6);
        join_none
        while (out_o !== 1'b0 && n < 20000) begin
            cyc(1);
            n++;
        end
        check(n < 20000 && out_oe === 1'b1, "no readback frame");
        for (int i = 0; i < 37; i++) begin
            cyc(625);
            check(out_o === ef[i], $sformatf("frame bit %0d", i));
            if (i < 36) begin
                cyc(1250);
                check(out_o === ~ef[i+1], $sformatf("frame half %0d", i + 1));
                cyc(625);
            end
            if (i == 4) begin
                fork
                    t_fifo();
                join_none
            end
        end
    endtask : t_read
    task automatic t_fifo;
        // queued behind the readout: two frame ends and six bits fill all 8 slots
        i_scsp_host_model.send(12'h033, 6);
        cyc(3100);
        check(rx_rdy === 1'b0, "command buffer not full");
    endtask : t_fifo
    task automatic t_cal;
        int n;
        n = 0;
        // the request queued during the readout starts once the frame ends
        while (cal_start !== 1'b1 && n < 20000) begin
            cyc(1);
            n++;
        end
        check(n < 20000, "no calibration start");
        cal_ok = 1'b1;
        cal_done = 1'b1;
        cyc(1);
        cal_done = 1'b0;
        cyc(2);
        check(cmd_oe === 1'b1 && cmd_line === 1'b1, "status not driven");
        cyc(STAT);
        check(cmd_oe === 1'b0, "status not released");
        check(rx_rdy === 1'b1, "command buffer not drained");
    endtask : t_cal
    initial begin
        cyc(10);
        reset = 1'b0;
        cyc(4);
        t_open_drain();
        t_write();
        t_read();
        t_cal();
        finish_test();
    end
endmodule : tb_sensor_config_serial_port
`default_nettype wire
